//--- rtl/tsa_status_alarm.v
// Functional notes
// - busy bit 7 high during conversion
// - not-ready bit 6 high for power-up
// - reserved bits read as zero
// - summary bits 3..0 OR status regs 4..1
// - summary at 0x02, read-only, resets 0x00
// - short and open diode faults reported
// - faulted channel reads 0 or -128
// - diode fault register at 0x07 layout
// - first alarm status at 0x08 layout
// - alarm bit sets at or above limit
// - alarm clears below limit minus hysteresis
// - remotes 1,2 use dedicated first limits
// - unmasked set bit activates alarm output
// - output inactive when all bits clear
// - mask bit blocks channel, resets 0x19
`include "tsa_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tsa_status_alarm #(
   parameter TW        = 11,
   parameter NR_CYCLES = `TSA_NR_CYCLES
) (
   // clock, reset, enable
   input  wire          mclk,
   input  wire          rstn,
   input  wire          ce,
   // command-byte register port
   input  wire [7:0]    cmd_addr,
   input  wire          cmd_rd,
   input  wire          cmd_wr,
   input  wire [7:0]    cmd_wdata,
   output reg  [7:0]    cmd_rdata_reg,
   output reg           cmd_rvalid_reg,
   // conversion engine
   input  wire          conv_busy,
   input  wire          conv_done,
   input  wire [2:0]    conv_chan,
   input  wire [TW-1:0] conv_temp_s,
   input  wire [TW-1:0] conv_temp_u,
   input  wire          diode_open,
   input  wire          diode_short,
   // limits, hysteresis and other status registers
   input  wire [TW-1:0] remote1_alarm_a_limit,
   input  wire [TW-1:0] remote2_alarm_a_limit,
   input  wire [TW-1:0] remote3_crit_limit,
   input  wire [TW-1:0] remote4_crit_limit,
   input  wire [TW-1:0] local_crit_limit,
   input  wire [TW-1:0] hyst,
   input  wire [4:0]    status3_bits,
   input  wire [4:0]    status4_bits,
   // reported reading after fault substitution
   output reg  [TW-1:0] rep_temp_s_reg,
   output reg  [TW-1:0] rep_temp_u_reg,
   output reg  [2:0]    rep_chan_reg,
   output reg           rep_valid_reg,
   // alarm pin
   output reg           first_alarm_out_n
);
   // ==========================================================
   // helpers
   function [TW-1:0] most_negative;
      input dummy;
      begin
         most_negative = {1'b1, {(TW-1){1'b0}}};
      end
   endfunction

   // remote channels are codes 1 to 4; local and unused codes are not
   function chan_is_remote;
      input [2:0] ch;
      begin
         chan_is_remote = (ch != `TSA_CH_LOCAL) && (ch < `TSA_NUM_CH);
      end
   endfunction

   // short-fault bit of a remote channel, the open bit sits one above
   function [2:0] fault_pos;
      input [2:0] ch;
      reg   [1:0] idx;
      begin
         idx       = ch[1:0] - 2'h1;
         fault_pos = {idx, 1'b0};
      end
   endfunction

   // ==========================================================
   // power-up not-ready timer
   // the count stops at the end, so the flag only comes back after a reset
   reg  [21:0] nr_cnt_reg;
   reg         nr_started_reg;
   reg         powerup_not_ready;

   always @(posedge mclk) begin
      if (!rstn) begin
         nr_cnt_reg        <= 22'h0;
         nr_started_reg    <= 1'b0;
         powerup_not_ready <= 1'b0;
      end else if (ce) begin
         if (!nr_started_reg) begin
            nr_started_reg    <= 1'b1;
            powerup_not_ready <= 1'b1;
         end else if (powerup_not_ready) begin
            if (nr_cnt_reg >= NR_CYCLES[21:0] - 22'h1) begin
               powerup_not_ready <= 1'b0;
            end else begin
               nr_cnt_reg <= nr_cnt_reg + 22'h1;
            end
         end
      end
   end

   // ==========================================================
   // fault substitution of the reading
   wire        ch_remote;
   wire        ch_fault;
   wire [TW-1:0] eff_temp_s;
   wire [2:0]    fault_bit;

   // codes above the last remote are refused, no substitution
   assign ch_remote  = chan_is_remote(conv_chan);
   assign fault_bit  = fault_pos(conv_chan);
   assign ch_fault   = ch_remote && (diode_open || diode_short);
   assign eff_temp_s = ch_fault ? most_negative(1'b0) : conv_temp_s;

   always @(posedge mclk) begin
      if (!rstn) begin
         rep_temp_s_reg <= {TW{1'b0}};
         rep_temp_u_reg <= {TW{1'b0}};
         rep_chan_reg   <= 3'h0;
         rep_valid_reg  <= 1'b0;
      end else if (ce) begin
         rep_valid_reg <= conv_done;
         if (conv_done) begin
            rep_chan_reg   <= conv_chan;
            rep_temp_s_reg <= eff_temp_s;
            rep_temp_u_reg <= ch_fault ? {TW{1'b0}} : conv_temp_u;
         end
      end
   end

   // ==========================================================
   // diode fault register, open in odd bit, short in even bit
   reg  [7:0] diode_fault_status;

   always @(posedge mclk) begin
      if (!rstn) begin
         diode_fault_status <= `TSA_STATUS_RST;
      end else if (ce && conv_done && ch_remote) begin
         diode_fault_status[fault_bit + 3'h1] <= diode_open;
         diode_fault_status[fault_bit]        <= diode_short;
      end
   end

   // named fields of the diode fault register
   wire remote4_open_fault;
   wire remote4_short_fault;
   wire remote3_open_fault;
   wire remote3_short_fault;
   wire remote2_open_fault;
   wire remote2_short_fault;
   wire remote1_open_fault;
   wire remote1_short_fault;

   assign remote4_open_fault  = diode_fault_status[7];
   assign remote4_short_fault = diode_fault_status[6];
   assign remote3_open_fault  = diode_fault_status[5];
   assign remote3_short_fault = diode_fault_status[4];
   assign remote2_open_fault  = diode_fault_status[3];
   assign remote2_short_fault = diode_fault_status[2];
   assign remote1_open_fault  = diode_fault_status[1];
   assign remote1_short_fault = diode_fault_status[0];

   // ==========================================================
   // per-channel first alarm flags
   wire [5*TW-1:0] lim_bus;
   wire [4:0]      alarm_a;
   wire [4:0]      upd_ch;

   // remotes 1,2 dedicated limits, others their critical limit
   assign lim_bus = {remote4_crit_limit, remote3_crit_limit,
                     remote2_alarm_a_limit, remote1_alarm_a_limit,
                     local_crit_limit};

   genvar gi;
   generate
      for (gi = 0; gi < `TSA_NUM_CH; gi = gi + 1) begin : g_ch
         assign upd_ch[gi] = conv_done && (conv_chan == gi);
         tsa_alarm_chan #(
            .TW (TW)
         ) u_chan (
            .mclk      (mclk),
            .rstn      (rstn),
            .ce        (ce),
            .upd       (upd_ch[gi]),
            .reading   (eff_temp_s),
            .limit     (lim_bus[gi*TW +: TW]),
            .hyst      (hyst),
            .alarm_reg (alarm_a[gi])
         );
      end
   endgenerate

   wire remote4_alarm_a;
   wire remote3_alarm_a;
   wire remote2_alarm_a;
   wire remote1_alarm_a;
   wire local_alarm_a;
   wire [7:0] first_alarm_status;

   assign remote4_alarm_a = alarm_a[4];
   assign remote3_alarm_a = alarm_a[3];
   assign remote2_alarm_a = alarm_a[2];
   assign remote1_alarm_a = alarm_a[1];
   assign local_alarm_a   = alarm_a[0];
   assign first_alarm_status = {3'h0, remote4_alarm_a, remote3_alarm_a,
                                remote2_alarm_a, remote1_alarm_a,
                                local_alarm_a};

   // ==========================================================
   // mask register, the only writable location here
   reg  [4:0] alarm_a_mask_reg;
   wire       mask_wr_hit;

   // writes to status locations match nothing and fall away
   assign mask_wr_hit = ce && cmd_wr &&
                        (cmd_addr == `TSA_CMD_ALARM_A_MSK);

   always @(posedge mclk) begin
      if (!rstn) begin
         alarm_a_mask_reg <= `TSA_MASK_RST;
      end else if (mask_wr_hit) begin
         alarm_a_mask_reg <= cmd_wdata[4:0];
      end
   end

   // ==========================================================
   // alarm pin: low while any unmasked flag is set
   wire [4:0] alarm_a_unmasked;

   assign alarm_a_unmasked = alarm_a & ~alarm_a_mask_reg;

   always @(posedge mclk) begin
      if (!rstn) begin
         first_alarm_out_n <= 1'b1;
      end else if (ce) begin
         first_alarm_out_n <= ~|alarm_a_unmasked;
      end
   end

   // ==========================================================
   // summary register
   wire [7:0] summary_status;

   // any-bit flags of status registers 4 down to 1
   wire status4_any_flag;
   wire status3_any_flag;
   wire status2_any_flag;
   wire status1_any_flag;

   assign status4_any_flag = |status4_bits;
   assign status3_any_flag = |status3_bits;
   assign status2_any_flag = |first_alarm_status;
   assign status1_any_flag = |{remote4_open_fault, remote4_short_fault,
                               remote3_open_fault, remote3_short_fault,
                               remote2_open_fault, remote2_short_fault,
                               remote1_open_fault, remote1_short_fault};

   assign summary_status = {conv_busy,
                            powerup_not_ready,
                            2'h0,
                            status4_any_flag,
                            status3_any_flag,
                            status2_any_flag,
                            status1_any_flag};

   // ==========================================================
   // read mux, writes to status locations have no effect
   reg  [7:0] rd_mux;

   always @* begin
      case (cmd_addr)
         `TSA_CMD_SUMMARY:     rd_mux = summary_status;
         `TSA_CMD_DIODE_FAULT: rd_mux = diode_fault_status;
         `TSA_CMD_ALARM_A:     rd_mux = first_alarm_status;
         `TSA_CMD_ALARM_A_MSK: rd_mux = {3'h0, alarm_a_mask_reg};
         default:              rd_mux = 8'h00;
      endcase
   end

   // registered read data, one cycle after the strobe
   always @(posedge mclk) begin
      if (!rstn) begin
         cmd_rdata_reg  <= `TSA_SUMMARY_RST;
         cmd_rvalid_reg <= 1'b0;
      end else if (ce) begin
         cmd_rvalid_reg <= cmd_rd;
         if (cmd_rd) begin
            cmd_rdata_reg <= rd_mux;
         end
      end
   end
endmodule
`default_nettype wire

//--- pkg/tsa_defs.vh
`ifndef TSA_DEFS_VH
`define TSA_DEFS_VH
// ==========================================================
// command byte offsets
`define TSA_CMD_SUMMARY     8'h02
`define TSA_CMD_DIODE_FAULT 8'h07
`define TSA_CMD_ALARM_A     8'h08
`define TSA_CMD_ALARM_A_MSK 8'h0c
// ==========================================================
// summary register fields
`define TSA_SUM_BUSY_BIT    7
`define TSA_SUM_NR_BIT      6
// ==========================================================
// reset values
`define TSA_SUMMARY_RST     8'h00
`define TSA_STATUS_RST      8'h00
`define TSA_MASK_RST        5'h19
// ==========================================================
// channel codes on the conversion port
`define TSA_CH_LOCAL        3'h0
`define TSA_NUM_CH          5
// ==========================================================
// timing: power-up not-ready time and clock rate
`define TSA_NR_TIME_US      30000
`define TSA_CLK_MHZ         50
`define TSA_NR_CYCLES       (`TSA_NR_TIME_US * `TSA_CLK_MHZ)
`endif

//--- rtl/tsa_alarm_chan.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// one channel threshold flag with hysteresis
module tsa_alarm_chan #(
   parameter TW = 11
) (
   // clock and reset
   input  wire          mclk,
   input  wire          rstn,
   input  wire          ce,
   // update strobe and operands
   input  wire          upd,
   input  wire [TW-1:0] reading,
   input  wire [TW-1:0] limit,
   input  wire [TW-1:0] hyst,
   // flag
   output reg           alarm_reg
);
   wire signed [TW+1:0] rd_x;
   wire signed [TW+1:0] lim_x;
   wire signed [TW+1:0] low_x;

   // signed compare operands, widened to avoid overflow
   assign rd_x  = {{2{reading[TW-1]}}, reading};
   assign lim_x = {{2{limit[TW-1]}}, limit};
   assign low_x = lim_x - {2'h0, hyst};

   // set at or above limit, clear below limit minus hysteresis
   always @(posedge mclk) begin
      if (!rstn) begin
         alarm_reg <= 1'b0;
      end else if (ce && upd) begin
         if (rd_x >= lim_x) begin
            alarm_reg <= 1'b1;
         end else if (rd_x < low_x) begin
            alarm_reg <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

//--- bench/tsa_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host side of the register port, one byte per request
module tsa_host_model (
   // clock
   input  wire logic       mclk,
   // requests from the bench
   input  wire logic       go,
   input  wire logic       gw,
   input  wire logic [7:0] ga,
   input  wire logic [7:0] gd,
   // register port
   output var  logic       cmd_rd,
   output var  logic       cmd_wr,
   output var  logic [7:0] cmd_addr,
   output var  logic [7:0] cmd_wdata,
   input  wire logic [7:0] cmd_rdata_reg,
   input  wire logic       cmd_rvalid_reg,
   // answer to the bench
   output var  logic       done,
   output var  logic [7:0] hd
);
   // one-cycle strobes, answer caught at the valid edge
   always @(posedge mclk) begin
      cmd_rd <= go;
      cmd_wr <= gw;
      cmd_addr <= ga;
      cmd_wdata <= gd;
      done <= cmd_rvalid_reg;
      if (cmd_rvalid_reg) hd <= cmd_rdata_reg;
   end
endmodule
`default_nettype wire

//--- bench/tsa_status_alarm_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker for the status and alarm block
module tsa_status_alarm_checker #(
   parameter TW = 11
) (
   input wire logic          mclk,
   input wire logic          rstn,
   input wire logic          ce,
   input wire logic [7:0]    cmd_addr,
   input wire logic          cmd_rd,
   input wire logic [7:0]    cmd_rdata_reg,
   input wire logic          cmd_rvalid_reg,
   input wire logic          conv_busy,
   input wire logic          conv_done,
   input wire logic [2:0]    conv_chan,
   input wire logic          diode_open,
   input wire logic          diode_short,
   input wire logic [TW-1:0] rep_temp_s_reg,
   input wire logic [TW-1:0] rep_temp_u_reg,
   input wire logic          rep_valid_reg
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   read_answer_a: assert property (ce && cmd_rd |=> cmd_rvalid_reg)
      else $error("read without answer");
   read_quiet_a: assert property (ce && !cmd_rd |=> !cmd_rvalid_reg)
      else $error("answer without read");
   busy_flag_a: assert property (ce && cmd_rd && cmd_addr == 8'h02
      |=> cmd_rdata_reg[7] == $past(conv_busy)) else $error("busy bit");
   sum_reserved_a: assert property (ce && cmd_rd && cmd_addr == 8'h02
      |=> cmd_rdata_reg[5:4] == 2'h0) else $error("summary reserved");
   alarm_reserved_a: assert property (ce && cmd_rd && cmd_addr == 8'h08
      |=> cmd_rdata_reg[7:5] == 3'h0) else $error("alarm reserved");
   unmapped_zero_a: assert property (ce && cmd_rd && cmd_addr > 8'h0c
      |=> cmd_rdata_reg == 8'h00) else $error("unmapped read");
   report_strobe_a: assert property (ce && conv_done |=> rep_valid_reg)
      else $error("no report strobe");
   fault_temp_a: assert property (ce && conv_done && conv_chan != 3'h0
      && conv_chan < 3'h5 && (diode_open || diode_short) |=>
      rep_temp_u_reg == 0 && rep_temp_s_reg == {1'b1, {(TW-1){1'b0}}})
      else $error("fault reading");
endmodule
bind tsa_status_alarm tsa_status_alarm_checker #(.TW(TW)) u_chk (
   .mclk(mclk), .rstn(rstn), .ce(ce), .cmd_addr(cmd_addr),
   .cmd_rd(cmd_rd), .cmd_rdata_reg(cmd_rdata_reg),
   .cmd_rvalid_reg(cmd_rvalid_reg), .conv_busy(conv_busy),
   .conv_done(conv_done), .conv_chan(conv_chan), .diode_open(diode_open),
   .diode_short(diode_short), .rep_temp_s_reg(rep_temp_s_reg),
   .rep_temp_u_reg(rep_temp_u_reg), .rep_valid_reg(rep_valid_reg));
`default_nettype wire

//--- bench/test_tsa_status_alarm.sv
`timescale 1ns/1ps
`default_nettype none
module test_tsa_status_alarm;
   logic        mclk = 0, rstn = 0, ce = 1, conv_busy = 0, conv_done = 0;
   logic        diode_open = 0, diode_short = 0, go = 0, gw = 0, pin;
   logic        cmd_rd, cmd_wr, rv, done, rep_v;
   logic [7:0]  ga = 0, gd = 0, hd, cmd_addr, cmd_wdata, rdata;
   logic [2:0]  conv_chan = 0, rep_c;
   logic [10:0] ts = 0, rs, ru;
   logic [10:0] l0 = 11'd80, l1 = 11'd100, l2 = 11'd50, l3 = 11'd60;
   logic [10:0] l4 = 11'd70, hy = 11'd10;
   logic [4:0]  s3 = 0, s4 = 0;
   integer      error_cnt = 0, samples_checked = 0;
   // ==========================================================
   // clock, host and design
   always #10 mclk = ~mclk;
   tsa_host_model host (.mclk(mclk), .go(go), .gw(gw), .ga(ga), .gd(gd),
      .cmd_rd(cmd_rd), .cmd_wr(cmd_wr), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_rdata_reg(rdata), .cmd_rvalid_reg(rv),
      .done(done), .hd(hd));
   tsa_status_alarm #(.TW(11), .NR_CYCLES(16)) DUT (.mclk(mclk),
      .rstn(rstn), .ce(ce), .cmd_addr(cmd_addr), .cmd_rd(cmd_rd),
      .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .cmd_rdata_reg(rdata),
      .cmd_rvalid_reg(rv), .conv_busy(conv_busy), .conv_done(conv_done),
      .conv_chan(conv_chan), .conv_temp_s(ts), .conv_temp_u(ts),
      .diode_open(diode_open), .diode_short(diode_short),
      .remote1_alarm_a_limit(l1), .remote2_alarm_a_limit(l2),
      .remote3_crit_limit(l3), .remote4_crit_limit(l4),
      .local_crit_limit(l0), .hyst(hy), .status3_bits(s3),
      .status4_bits(s4), .rep_temp_s_reg(rs), .rep_temp_u_reg(ru),
      .rep_chan_reg(rep_c), .rep_valid_reg(rep_v),
      .first_alarm_out_n(pin));
   // ==========================================================
   // shared tasks
   task chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("Error at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task chk_t(input logic [10:0] got, input logic [10:0] exp);
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("Error at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      integer i;
      @(posedge mclk) go <= 1;
      ga <= a;
      @(posedge mclk) go <= 0;
      for (i = 0; i < 8 && done !== 1'b1; i = i + 1) begin
         @(posedge mclk);
         #1;
      end
      chk({7'h0, done}, 8'h01);
      chk(hd, e);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk) gw <= 1;
      ga <= a;
      gd <= d;
      @(posedge mclk) gw <= 0;
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task cv(input logic [2:0] c, input logic [10:0] t, input logic o, s);
      @(posedge mclk) conv_done <= 1;
      conv_chan <= c;
      ts <= t;
      diode_open <= o;
      diode_short <= s;
      @(posedge mclk) conv_done <= 0;
      @(posedge mclk);
      #1;
      if (c != 3'h0 && (o || s)) begin
         chk_t(rs, 11'h400);
         chk_t(ru, 11'h000);
      end else begin
         chk_t(rs, t);
         chk_t(ru, t);
      end
      chk({5'h0, rep_c}, {5'h0, c});
   endtask
   task final_report;
      $display("checked %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task t_powerup;
      rd(8'h02, 8'h40);
      rd(8'h0c, 8'h19);
      repeat (20) @(posedge mclk);
      rd(8'h02, 8'h00);
      rd(8'h33, 8'h00);
      @(posedge mclk) conv_busy <= 1;
      rd(8'h02, 8'h80);
      @(posedge mclk) conv_busy <= 0;
      rd(8'h02, 8'h00);
   endtask
   task t_hyst;
      cv(3'h1, 11'd100, 0, 0);
      chk({7'h0, pin}, 8'h00);
      rd(8'h08, 8'h02);
      rd(8'h02, 8'h02);
      wr(8'h08, 8'h00);
      rd(8'h08, 8'h02);
      cv(3'h1, 11'd90, 0, 0);
      rd(8'h08, 8'h02);
      cv(3'h1, 11'd89, 0, 0);
      chk({7'h0, pin}, 8'h01);
      rd(8'h08, 8'h00);
      @(posedge mclk) hy <= 11'd0;
      cv(3'h1, 11'd100, 0, 0);
      cv(3'h1, 11'd99, 0, 0);
      rd(8'h08, 8'h00);
      @(posedge mclk) hy <= 11'd10;
   endtask
   task t_mask;
      cv(3'h2, 11'd50, 0, 0);
      rd(8'h08, 8'h04);
      cv(3'h2, 11'd0, 0, 0);
      cv(3'h3, 11'd60, 0, 0);
      chk({7'h0, pin}, 8'h01);
      wr(8'h0c, 8'h00);
      chk({7'h0, pin}, 8'h00);
      cv(3'h3, 11'd0, 0, 0);
      chk({7'h0, pin}, 8'h01);
      wr(8'h0c, 8'h19);
      cv(3'h0, 11'd80, 0, 1);
      chk({7'h0, pin}, 8'h01);
      rd(8'h08, 8'h01);
      rd(8'h07, 8'h00);
      cv(3'h0, 11'd69, 0, 0);
      rd(8'h08, 8'h00);
   endtask
   task t_fault;
      cv(3'h2, 11'd60, 0, 1);
      rd(8'h07, 8'h04);
      cv(3'h4, 11'd5, 1, 0);
      wr(8'h07, 8'h00);
      rd(8'h07, 8'h84);
      rd(8'h08, 8'h00);
      @(posedge mclk) s3 <= 5'h01;
      s4 <= 5'h10;
      rd(8'h02, 8'h0d);
   endtask
   task t_freeze;
      @(posedge mclk) ce <= 0;
      conv_done <= 1;
      conv_chan <= 3'h1;
      ts <= 11'd100;
      @(posedge mclk) conv_done <= 0;
      @(posedge mclk) ce <= 1;
      rd(8'h08, 8'h00);
      chk({7'h0, pin}, 8'h01);
   endtask
   task t_reset;
      cv(3'h1, 11'd100, 0, 0);
      chk({7'h0, pin}, 8'h00);
      @(posedge mclk) rstn <= 0;
      repeat (2) @(posedge mclk);
      rstn <= 1;
      #1;
      chk({7'h0, pin}, 8'h01);
      rd(8'h08, 8'h00);
      rd(8'h07, 8'h00);
      rd(8'h02, 8'h4c);
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      rstn <= 1;
      t_powerup;
      t_hyst;
      t_mask;
      t_fault;
      t_freeze;
      t_reset;
      final_report;
   end
   // watchdog
   initial begin
      #100000;
      error_cnt = error_cnt + 1;
      final_report;
   end
endmodule
`default_nettype wire
